// [logic/hcu_pkg.sv]
/*
 * Shared constants and types for the host serial link block: frame layout, rate limits
 * derived from the system clock, flow control thresholds and carrier structs.
 * Assumes a single 25 MHz clock and a synchronous, active-high reset.
 */

package hcu_pkg;

    // ------------------------------------------------------------------
    // Clock and rate limits
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned RATE_MIN_BPS = 37_500;
    localparam int unsigned RATE_MAX_BPS = 4_000_000;
    localparam int DIV_W = 16;
    // Longest allowed bit rounds down, shortest allowed bit rounds up.
    localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'((CLK_HZ + RATE_MAX_BPS - 1) / RATE_MAX_BPS);
    localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / RATE_MIN_BPS);
    localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'(CLK_HZ / 115_200);

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int DATA_BITS = 8;
    localparam int BIT_CNT_W = 3;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = BIT_CNT_W'(DATA_BITS - 1);
    localparam logic LINE_IDLE = 1'b1;
    localparam logic START_LVL = 1'b0;
    localparam logic STOP_LVL = 1'b1;
    localparam logic FLOW_READY_N = 1'b0;
    localparam logic FLOW_HALT_N = 1'b1;

    // ------------------------------------------------------------------
    // Flow control
    // ------------------------------------------------------------------
    localparam int FIFO_DEPTH = 32;
    localparam int HOST_OVERRUN_BYTES = 16;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DIV_W-1:0] bit_div;
        logic parity_en;
        logic parity_odd;
    } hcu_cfg_t;

    typedef struct packed {
        logic [DATA_BITS-1:0] data;
        logic parity_err;
        logic frame_err;
    } hcu_rx_byte_t;

    typedef enum {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_PARITY,
        ST_STOP
    } hcu_state_t;

    // Clamp a requested divisor to the supported rate window.
    function automatic logic [DIV_W-1:0] clamp_div(input logic [DIV_W-1:0] d);
        if (d < DIV_MIN) begin
            return DIV_MIN;
        end
        if (d > DIV_MAX) begin
            return DIV_MAX;
        end
        return d;
    endfunction

    function automatic logic parity_of(input logic [DATA_BITS-1:0] d, input logic odd);
        return (^d) ^ odd;
    endfunction

endpackage

// [logic/hcu_rx.sv]
/*
 * Receive framer: finds the start edge, samples each bit at its centre and hands out
 * one byte with its parity and framing status as a one-cycle pulse.
 * Assumes the line input is already synchronous to clk_in.
 */
`timescale 1ns/10ps
`default_nettype none

module hcu_rx
    import hcu_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Configuration
    input wire hcu_cfg_t cfg_in,
    // Serial line
    input wire logic rxd_in,
    // Received byte
    output logic done_out,
    output hcu_rx_byte_t byte_out
);

    hcu_state_t state_r;
    logic [DIV_W-1:0] cnt_r;
    logic [BIT_CNT_W-1:0] bit_r;
    logic [DATA_BITS-1:0] shift_r;
    logic perr_r;
    logic [DIV_W-1:0] div;
    logic tick;

    assign div = clamp_div(cfg_in.bit_div);
    assign tick = (cnt_r == '0);

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    // Sampling at mid-bit leaves half a bit of margin, well beyond the per-bit jitter.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            bit_r <= '0;
            shift_r <= '0;
            perr_r <= 1'b0;
            done_out <= 1'b0;
            byte_out <= '0;
        end else begin
            done_out <= 1'b0;
            cnt_r <= tick ? '0 : cnt_r - 1'b1;
            case (state_r)
                ST_IDLE: begin
                    if (rxd_in == START_LVL) begin
                        cnt_r <= div >> 1;
                        state_r <= ST_START;
                    end
                end
                ST_START: begin
                    if (tick) begin
                        // A glitch shorter than half a bit is not a start bit.
                        state_r <= (rxd_in == START_LVL) ? ST_DATA : ST_IDLE;
                        cnt_r <= div - 1'b1;
                        bit_r <= '0;
                    end
                end
                ST_DATA: begin
                    if (tick) begin
                        shift_r <= {rxd_in, shift_r[DATA_BITS-1:1]};
                        cnt_r <= div - 1'b1;
                        bit_r <= bit_r + 1'b1;
                        if (bit_r == LAST_BIT) begin
                            state_r <= cfg_in.parity_en ? ST_PARITY : ST_STOP;
                        end
                    end
                end
                ST_PARITY: begin
                    if (tick) begin
                        perr_r <= rxd_in != parity_of(shift_r, cfg_in.parity_odd);
                        cnt_r <= div - 1'b1;
                        state_r <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (tick) begin
                        byte_out.data <= shift_r;
                        byte_out.parity_err <= cfg_in.parity_en & perr_r;
                        byte_out.frame_err <= rxd_in != STOP_LVL;
                        done_out <= 1'b1;
                        perr_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// [logic/hcu_uart.sv]
/*
 * Host serial link with hardware flow control: transmitter paced by clear-to-send,
 * receiver feeding a byte store that raises request-to-send before it can overflow.
 * Assumes all inputs are synchronous to clk_in; pin levels are active low for flow.
 */
`timescale 1ns/10ps
`default_nettype none

module hcu_uart
    import hcu_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int HEADROOM = HOST_OVERRUN_BYTES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Configuration
    input wire hcu_cfg_t cfg_in,
    // Transmit byte stream
    input wire logic tx_valid_in,
    input wire logic [DATA_BITS-1:0] tx_data_in,
    output logic tx_ready_out,
    // Receive byte stream
    output logic rx_valid_out,
    output hcu_rx_byte_t rx_byte_out,
    input wire logic rx_ready_in,
    output logic rx_overrun_out,
    // Serial pins
    output logic txd_out,
    input wire logic rxd_in,
    output logic rts_n_out,
    input wire logic cts_n_in,
    // Status
    output logic tx_busy_out
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] RTS_LEVEL = (AW+1)'(DEPTH - HEADROOM);
    localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    hcu_state_t tx_state_r;
    logic [DIV_W-1:0] tx_cnt_r;
    logic [BIT_CNT_W-1:0] tx_bit_r;
    logic [DATA_BITS-1:0] tx_shift_r;
    logic tx_par_r;
    logic tx_take;
    logic tx_tick;
    logic [DIV_W-1:0] tx_div;

    assign tx_div = clamp_div(cfg_in.bit_div);
    assign tx_tick = (tx_cnt_r == '0);
    // Flow is checked only between bytes, so a byte already started always completes.
    assign tx_take = (tx_state_r == ST_IDLE) && tx_valid_in && tx_ready_out
                     && (cts_n_in == FLOW_READY_N);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tx_ready_out <= 1'b0;
        end else begin
            tx_ready_out <= (tx_state_r == ST_IDLE) && (cts_n_in == FLOW_READY_N)
                            && !tx_take;
        end
    end

    // Busy stays up one cycle past the stop bit, while the sequencer returns to idle.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tx_busy_out <= 1'b0;
        end else if (tx_take) begin
            tx_busy_out <= 1'b1;
        end else if (tx_state_r == ST_IDLE) begin
            tx_busy_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tx_state_r <= ST_IDLE;
            tx_cnt_r <= '0;
            tx_bit_r <= '0;
            tx_shift_r <= '0;
            tx_par_r <= 1'b0;
            txd_out <= LINE_IDLE;
        end else begin
            tx_cnt_r <= tx_tick ? '0 : tx_cnt_r - 1'b1;
            case (tx_state_r)
                ST_IDLE: begin
                    txd_out <= LINE_IDLE;
                    if (tx_take) begin
                        tx_shift_r <= tx_data_in;
                        tx_par_r <= parity_of(tx_data_in, cfg_in.parity_odd);
                        tx_cnt_r <= tx_div - 1'b1;
                        txd_out <= START_LVL;
                        tx_state_r <= ST_START;
                    end
                end
                ST_START: begin
                    if (tx_tick) begin
                        txd_out <= tx_shift_r[0];
                        tx_shift_r <= tx_shift_r >> 1;
                        tx_bit_r <= '0;
                        tx_cnt_r <= tx_div - 1'b1;
                        tx_state_r <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (tx_tick) begin
                        tx_cnt_r <= tx_div - 1'b1;
                        tx_bit_r <= tx_bit_r + 1'b1;
                        if (tx_bit_r != LAST_BIT) begin
                            txd_out <= tx_shift_r[0];
                            tx_shift_r <= tx_shift_r >> 1;
                        end else if (cfg_in.parity_en) begin
                            txd_out <= tx_par_r;
                            tx_state_r <= ST_PARITY;
                        end else begin
                            txd_out <= STOP_LVL;
                            tx_state_r <= ST_STOP;
                        end
                    end
                end
                ST_PARITY: begin
                    if (tx_tick) begin
                        txd_out <= STOP_LVL;
                        tx_cnt_r <= tx_div - 1'b1;
                        tx_state_r <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    // Every bit is exactly one divisor long, so the bit rate error is that
                    // of the divisor alone; back-to-back bytes add at least two idle cycles.
                    if (tx_tick) begin
                        tx_state_r <= ST_IDLE;
                    end
                end
                default: begin
                    tx_state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Receiver and byte store
    // ------------------------------------------------------------------
    logic rx_done;
    hcu_rx_byte_t rx_byte;

    hcu_rx u_rx (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .cfg_in(cfg_in),
        .rxd_in(rxd_in),
        .done_out(rx_done),
        .byte_out(rx_byte)
    );

    hcu_rx_byte_t mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign push = rx_done && (count_r != FULL_LEVEL);
    assign pop = (count_r != '0) && (!rx_valid_out || rx_ready_in);

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_r] <= rx_byte;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_r + AW'(push);
            rd_ptr_r <= rd_ptr_r + AW'(pop);
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rx_valid_out <= 1'b0;
            rx_byte_out <= '0;
        end else if (pop) begin
            rx_valid_out <= 1'b1;
            rx_byte_out <= mem[rd_ptr_r];
        end else if (rx_ready_in) begin
            rx_valid_out <= 1'b0;
        end
    end

    // A byte arriving with no room is lost; the flag is sticky until reset.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rx_overrun_out <= 1'b0;
        end else if (rx_done && !push) begin
            rx_overrun_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Request-to-send
    // ------------------------------------------------------------------
    // Halting with HEADROOM free slots absorbs what the host may still send.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rts_n_out <= FLOW_HALT_N;
        end else begin
            rts_n_out <= (count_r >= RTS_LEVEL) ? FLOW_HALT_N : FLOW_READY_N;
        end
    end

endmodule

`default_nettype wire

// [tb/hcu_uart_properties.sv]
/* Checker for the host serial link top: transmit framing, bit timing, flow halt.
   Assumes it is bound into hcu_uart and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none

module hcu_uart_properties
    import hcu_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int HEADROOM = HOST_OVERRUN_BYTES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Watched ports
    input wire hcu_cfg_t cfg_in,
    input wire logic tx_valid_in,
    input wire logic [DATA_BITS-1:0] tx_data_in,
    input wire logic tx_ready_out,
    input wire logic rx_valid_out,
    input wire logic rx_overrun_out,
    input wire logic txd_out,
    input wire logic rts_n_out,
    input wire logic cts_n_in,
    input wire logic tx_busy_out
);
    // --------
    // Helpers
    // --------
    logic take;
    logic [DATA_BITS-1:0] data_r;
    logic pen_r;
    logic odd_r;
    int cnt_r;
    int d;
    int idx;
    int frame_stop_bit;
    assign take = tx_valid_in && tx_ready_out && !cts_n_in;
    always_comb begin
        d = (cfg_in.bit_div < DIV_MIN) ? int'(DIV_MIN) :
            (cfg_in.bit_div > DIV_MAX) ? int'(DIV_MAX) : int'(cfg_in.bit_div);
        idx = cnt_r / d;
        frame_stop_bit = pen_r ? 10 : 9;
    end
    // Cycle k after the take sees cnt_r == k, so idx is the bit on the line.
    always_ff @(posedge clk_in) begin
        cnt_r <= (sys_rst_in || !tx_busy_out) ? 0 : cnt_r + 1;
    end
    always_ff @(posedge clk_in) begin
        if (take) begin
            data_r <= tx_data_in;
            pen_r <= cfg_in.parity_en;
            odd_r <= cfg_in.parity_odd;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // --------
    // Properties
    // --------
    AST_RESET_VALS: assert property (disable iff (1'b0) sys_rst_in |=> txd_out &&
        rts_n_out && !tx_busy_out && !tx_ready_out && !rx_valid_out && !rx_overrun_out)
        else $error("reset values wrong");
    AST_TAKE_START: assert property (take |=> !txd_out && tx_busy_out)
        else $error("no start after take");
    AST_START_BIT: assert property (tx_busy_out && idx == 0 |-> txd_out == START_LVL)
        else $error("start bit wrong");
    AST_TX_BITS: assert property (tx_busy_out && idx >= 1 && idx <= 8 |->
        txd_out == data_r[3'(idx - 1)]) else $error("data bit wrong");
    AST_TX_PARITY: assert property (tx_busy_out && pen_r && idx == 9 |->
        txd_out == (^data_r ^ odd_r)) else $error("parity bit wrong");
    AST_TX_STOP: assert property (tx_busy_out && idx == frame_stop_bit |-> txd_out == STOP_LVL)
        else $error("stop bit wrong");
    AST_FRAME_LEN: assert property ($fell(tx_busy_out) && !$past(sys_rst_in) |->
        cnt_r == (frame_stop_bit + 1) * d + 1) else $error("frame length wrong");
    AST_IDLE_HIGH: assert property (!tx_busy_out |-> txd_out == LINE_IDLE)
        else $error("line not idle high");
    AST_CTS_HALT: assert property (cts_n_in && !tx_busy_out |=> !tx_busy_out)
        else $error("sent while halted");
    COV_TAKE: cover property (take);
    COV_PAR: cover property (take && cfg_in.parity_en);
    COV_RTS: cover property ($rose(rts_n_out));
    COV_HALT: cover property (cts_n_in && tx_busy_out);
endmodule

bind hcu_uart hcu_uart_properties #(.DEPTH(DEPTH), .HEADROOM(HEADROOM)) u_props (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cfg_in(cfg_in), .tx_valid_in(tx_valid_in),
    .tx_data_in(tx_data_in), .tx_ready_out(tx_ready_out), .rx_valid_out(rx_valid_out),
    .rx_overrun_out(rx_overrun_out), .txd_out(txd_out), .rts_n_out(rts_n_out),
    .cts_n_in(cts_n_in), .tx_busy_out(tx_busy_out));
`default_nettype wire

// [tb/hcu_host_model.sv]
/* Host side serial port: decodes frames from the device and sends frames to it.
   Assumes send is called just after a rising clock edge. */
`timescale 1ns/10ps
`default_nettype none

module hcu_host_model
    import hcu_pkg::*;
(
    // Clock and settings
    input wire logic clk_in,
    input wire hcu_cfg_t cfg_in,
    // Serial lines
    input wire logic txd_in,
    output logic rxd_out
);
    // --------
    // Frames
    // --------
    logic [9:0] got_q[$];
    int d;
    always_comb begin
        d = (cfg_in.bit_div < DIV_MIN) ? int'(DIV_MIN) :
            (cfg_in.bit_div > DIV_MAX) ? int'(DIV_MAX) : int'(cfg_in.bit_div);
    end
    initial rxd_out = LINE_IDLE;
    // Sends at once when called; the caller owns the request-to-send check.
    task automatic send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
        logic [10:0] f;
        f = {~bad_stop, ~bad_stop, b, START_LVL};
        if (cfg_in.parity_en) f[9] = ^b ^ cfg_in.parity_odd ^ bad_par;
        for (int i = 0; i < (cfg_in.parity_en ? 11 : 10); i++) begin
            rxd_out = f[i];
            repeat (d) @(posedge clk_in);
            #2;
        end
        rxd_out = LINE_IDLE;
        // One idle cycle keeps back-to-back frames from driving the line twice at once.
        @(posedge clk_in);
        #2;
    endtask
    // Samples on the falling clock so register updates never race the read.
    always begin
        logic [9:0] w;
        @(negedge txd_in);
        w = '0;
        repeat (d / 2) @(negedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (d) @(negedge clk_in);
            w[i] = txd_in;
        end
        if (cfg_in.parity_en) begin
            repeat (d) @(negedge clk_in);
            w[8] = txd_in;
        end
        repeat (d) @(negedge clk_in);
        w[9] = txd_in;
        got_q.push_back(w);
    end
endmodule
`default_nettype wire

// [tb/hcu_uart_bench.sv]
/* Self-checking bench for hcu_uart with a host model on the serial pins.
   Assumes the checker is bound in and the package constants are in use. */
`timescale 1ns/10ps
`default_nettype none

module hcu_uart_bench
    import hcu_pkg::*;
;
    // --------
    // Set-up
    // --------
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    hcu_cfg_t cfg = '{16'h0008, 1'b0, 1'b0};
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic rx_ready = 1'b0;
    logic cts_n = 1'b0;
    logic tx_ready, rx_valid, rx_overrun, txd, rxd, rts_n, tx_busy;
    hcu_rx_byte_t rx_byte;
    int n_mismatch = 0;
    int checked = 0;
    always #20 clk_in = ~clk_in;
    hcu_uart uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cfg_in(cfg),
        .tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_ready_out(tx_ready),
        .rx_valid_out(rx_valid), .rx_byte_out(rx_byte), .rx_ready_in(rx_ready),
        .rx_overrun_out(rx_overrun), .txd_out(txd), .rxd_in(rxd), .rts_n_out(rts_n),
        .cts_n_in(cts_n), .tx_busy_out(tx_busy));
    hcu_host_model host (.clk_in(clk_in), .cfg_in(cfg), .txd_in(txd), .rxd_out(rxd));
    // --------
    // Tasks
    // --------
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic hang();
        n_mismatch++;
        wrap_up();
    endtask
    task automatic send_tx(input logic [7:0] b, output int w);
        tx_valid = 1'b1;
        tx_data = b;
        for (w = 0; w < 9000; w++) begin
            @(negedge clk_in);
            if (tx_ready === 1'b1 && cts_n === 1'b0) break;
        end
        if (w == 9000) hang();
        step(1);
        tx_valid = 1'b0;
        step(1);
    endtask
    task automatic wait_got(input int n);
        int i;
        for (i = 0; i < 20000 && host.got_q.size() < n; i++) step(1);
        if (i == 20000) hang();
        step(10);
    endtask
    function automatic logic [15:0] frame(input logic [7:0] b);
        return 16'({1'b1, cfg.parity_en & (^b ^ cfg.parity_odd), b});
    endfunction
    task automatic t_tx();
        int w;
        for (int p = 0; p < 3; p++) begin
            cfg.parity_en = (p != 0);
            cfg.parity_odd = (p == 2);
            send_tx(8'ha5, w);
            send_tx(8'h3c, w);
            wait_got(2);
            chk(16'(host.got_q.pop_front()), frame(8'ha5));
            chk(16'(host.got_q.pop_front()), frame(8'h3c));
        end
        $display("t_tx done");
    endtask
    task automatic t_rate();
        int w;
        logic [15:0] divs [2] = '{16'h0003, 16'hffff};
        foreach (divs[k]) begin
            cfg.bit_div = divs[k];
            send_tx(8'h96, w);
            wait_got(1);
            chk(16'(host.got_q.pop_front()), frame(8'h96));
            step(700);
        end
        cfg.bit_div = 16'h0008;
        $display("t_rate done");
    endtask
    task automatic t_cts();
        int w;
        send_tx(8'h5a, w);
        step(20);
        cts_n = 1'b1;
        tx_valid = 1'b1;
        tx_data = 8'hc3;
        step(300);
        chk(16'(host.got_q.size()), 16'h0001);
        cts_n = 1'b0;
        send_tx(8'hc3, w);
        chk(16'(w < 50), 16'h0001);
        wait_got(2);
        chk(16'(host.got_q.pop_front()), frame(8'h5a));
        chk(16'(host.got_q.pop_front()), frame(8'hc3));
        $display("t_cts done");
    endtask
    task automatic t_rx();
        int i;
        logic [9:0] exp [3] = '{{8'h81, 2'b00}, {8'h7e, 2'b10}, {8'h42, 2'b01}};
        for (int k = 0; k < 3; k++) begin
            cfg.parity_odd = 1'(k);
            host.send(exp[k][9:2], exp[k][1], exp[k][0]);
            for (i = 0; i < 50 && rx_valid !== 1'b1; i++) step(1);
            if (i == 50) hang();
            chk(16'(rx_byte), 16'(exp[k]));
            rx_ready = 1'b1;
            step(1);
            rx_ready = 1'b0;
        end
        $display("t_rx done");
    endtask
    task automatic t_flow();
        int n;
        int got = 0;
        cfg.parity_en = 1'b0;
        for (n = 0; n < 40 && rts_n === 1'b0; n++) begin
            host.send(8'(n), 1'b0, 1'b0);
            step(2);
        end
        chk(16'(n >= 16 && n <= 17), 16'h0001);
        for (int k = 0; k < HOST_OVERRUN_BYTES; k++) host.send(8'(n + k), 1'b0, 1'b0);
        chk(16'({rts_n, rx_overrun}), 16'h0002);
        host.send(8'hee, 1'b0, 1'b0);
        chk(16'(rx_overrun), 16'h0001);
        rx_ready = 1'b1;
        for (int k = 0; k < 200; k++) begin
            @(negedge clk_in);
            if (rx_valid === 1'b1) begin
                chk(16'(rx_byte.data), 16'(got));
                got++;
            end
        end
        step(1);
        rx_ready = 1'b0;
        chk(16'(got), 16'(n + HOST_OVERRUN_BYTES));
        chk(16'(rts_n), 16'h0000);
        sys_rst_in = 1'b1;
        step(2);
        chk(16'({rts_n, rx_overrun, tx_busy}), 16'h0004);
        sys_rst_in = 1'b0;
        step(2);
        chk(16'(rts_n), 16'h0000);
        $display("t_flow done");
    endtask
    // --------
    // Sequence
    // --------
    initial begin
        step(10);
        chk(16'({txd, rts_n, tx_ready, rx_valid, tx_busy, rx_overrun}), 16'h0030);
        $display("t_reset done");
        sys_rst_in = 1'b0;
        step(2);
        t_tx();
        t_rate();
        t_cts();
        t_rx();
        t_flow();
        wrap_up();
    end
endmodule
`default_nettype wire
